// [include/irq_consts.svh]
/*
  Register offsets, field positions, reset values and timing figures of the
  interrupt latch, mask and input level monitor block.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH

// register offsets on the control port
`define OFS_INPUT_MONITOR 8'h2f
`define OFS_IRQ_CONFIG 8'h32
`define OFS_IRQ_MASK 8'h33
`define OFS_IRQ_FLAGS 8'h36

// interrupt_config fields
`define CFG_POLARITY_BIT 7
`define CFG_STYLE_HI 6
`define CFG_STYLE_LO 5
`define CFG_FILTER_BIT 2
`define CFG_RESET 8'h00

// mask and flag bit positions
`define EVT_ASP_CLK_ERR_BIT 7
`define EVT_PLL_LOCK_BIT 6
`define MASK_RESET 8'hff

// input monitor: input one sits in bit 7, input four in bit 4
`define MON_TOP_BIT 7
`define PIN_FUNC_GENERAL_INPUT 3'h1

// timing: pulse and repeat period in ms, system clock in kHz
`define IRQ_PULSE_MS 2
`define IRQ_PERIOD_MS 4
`define CLK_FREQ_KHZ 50000

`endif

// [include/irq_pkg.sv]
/*
  Types shared by the interrupt latch and input monitor modules.
  Assumes irq_consts.svh sits on the include path.
*/
package irq_pkg;
  `include "irq_consts.svh"

  // order follows the two-bit style field, 0 to 3
  typedef enum logic [1:0] {
    STYLE_LEVEL,
    STYLE_RESERVED,
    STYLE_REPEAT,
    STYLE_ONESHOT
  } irq_style_e;

  typedef logic [7:0] reg_byte_t;
endpackage : irq_pkg

// [src/input_sync.sv]
/*
  Two flip-flop synchroniser for a group of pin inputs, one chain per bit.
  Assumes the pins are asynchronous to clk.
*/
`timescale 1ns/100ps
module input_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins and synchronised levels
  input wire logic [WIDTH-1:0] pin_async,
  output logic [WIDTH-1:0] pin_sync
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_r;
      logic stable_r;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_r <= 1'b0;
          stable_r <= 1'b0;
        end else begin
          meta_r <= pin_async[i];
          stable_r <= meta_r;
        end
      end
      assign pin_sync[i] = stable_r;
    end
  endgenerate
endmodule : input_sync

// [src/pulse_timer.sv]
/*
  Millisecond pulse timer for the repeating and one-shot interrupt styles.
  Assumes periodic and oneshot_en are never high together.
*/
`timescale 1ns/100ps
module pulse_timer #(
  parameter int PULSE_CYCLES = 100000,
  parameter int PERIOD_CYCLES = 200000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic periodic,
  input wire logic oneshot_en,
  input wire logic trigger,
  // result
  output logic active
);
  localparam int W = $clog2(PERIOD_CYCLES + 1);
  localparam logic [W-1:0] PULSE_W = W'(PULSE_CYCLES);
  localparam logic [W-1:0] LAST_W = W'(PERIOD_CYCLES - 1);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // a fresh trigger restarts the one-shot, so the last event always gets a full pulse
  always_comb begin
    cnt_nxt = '0;
    if (periodic) begin
      cnt_nxt = (cnt_r >= LAST_W) ? '0 : cnt_r + W'(1);
    end else if (oneshot_en) begin
      if (trigger) begin
        cnt_nxt = PULSE_W;
      end else if (cnt_r != '0) begin
        cnt_nxt = cnt_r - W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign active = periodic ? (cnt_r < PULSE_W) : (oneshot_en && cnt_r != '0);
endmodule : pulse_timer

// [src/irq_latch_mask_and_input_monitor.sv]
/*
  Interrupt latch, mask and general input level monitor of an audio converter.
  Holds interrupt_config, interrupt_mask_0, interrupt_latched_flags_0 and
  input_level_monitor behind the decoded control port register strobes.
  Assumes the control port front end gives one-cycle reg_wr / reg_rd strobes
  on clk, and that event inputs come from logic on clk.
*/
// Contract
// - monitor bits 7..4 show input levels one to four; bits 3..0 read zero.
// - a pin feeds its monitor bit only when its function field equals one.
// - polarity bit zero drives the interrupt low-active, one drives it high-active.
// - style zero asserts while any unmasked flag is set; style one reserved.
// - style two asserts 2 ms in every 4 ms while unmasked flags stay set.
// - style three gives one 2 ms assertion per unmasked event.
// - readback filter zero shows all flags; one hides masked flags.
// - mask bit 7 blocks the port clock error event; resets set.
// - mask bit 6 blocks the PLL lock event; resets set.
// - flag bit 7 sets on a serial port clock error, self-clearing.
// - flag bit 6 sets on PLL lock; flag bits 5..0 read zero.
`timescale 1ns/100ps
`include "irq_consts.svh"
module irq_latch_mask_and_input_monitor
  import irq_pkg::*;
#(
  parameter int PULSE_CYCLES = `IRQ_PULSE_MS * `CLK_FREQ_KHZ,
  parameter int PERIOD_CYCLES = `IRQ_PERIOD_MS * `CLK_FREQ_KHZ
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rdata_valid,
  // events from the audio serial port and PLL
  input wire logic asp_clock_error,
  input wire logic pll_locked,
  // multi-function pins and their function fields
  input wire logic general_input_one,
  input wire logic general_input_two,
  input wire logic general_input_three,
  input wire logic general_input_four,
  input wire logic [2:0] pin_one_function_select,
  input wire logic [2:0] pin_two_function_select,
  input wire logic [2:0] pin_three_function_select,
  input wire logic [2:0] pin_four_function_select,
  // interrupt pin
  output logic irq_pin
);
  logic [3:0] pin_sync;
  logic [3:0] pin_is_input;
  logic [3:0] mon_levels;

  reg_byte_t cfg_r;
  reg_byte_t cfg_nxt;
  reg_byte_t mask_r;
  reg_byte_t mask_nxt;
  logic [1:0] flag_r;
  logic [1:0] flag_nxt;
  logic pll_locked_d_r;
  reg_byte_t rdata_r;
  reg_byte_t rdata_nxt;
  logic rvalid_r;
  logic irq_pin_r;
  logic irq_pin_nxt;

  logic wr_cfg;
  logic wr_mask;
  logic rd_flags;
  logic [1:0] evt_set;
  logic [1:0] evt_mask;
  logic [1:0] flag_view;
  logic pending;
  logic new_unmasked;
  logic polarity;
  logic filter_on;
  irq_style_e style;
  logic irq_assert_c;
  logic timer_active;

  // pins are asynchronous, so nothing reads them before two flops
  input_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_async({general_input_four, general_input_three, general_input_two,
                general_input_one}),
    .pin_sync(pin_sync)
  );

  assign pin_is_input = {pin_four_function_select == `PIN_FUNC_GENERAL_INPUT,
                         pin_three_function_select == `PIN_FUNC_GENERAL_INPUT,
                         pin_two_function_select == `PIN_FUNC_GENERAL_INPUT,
                         pin_one_function_select == `PIN_FUNC_GENERAL_INPUT};

  // input one lands in the top bit, so the order is reversed per bit
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_mon
      assign mon_levels[3-g] = pin_is_input[g] & pin_sync[g];
    end
  endgenerate

  assign polarity = cfg_r[`CFG_POLARITY_BIT];
  assign filter_on = cfg_r[`CFG_FILTER_BIT];
  assign style = irq_style_e'(cfg_r[`CFG_STYLE_HI:`CFG_STYLE_LO]);

  assign wr_cfg = reg_wr && reg_addr == `OFS_IRQ_CONFIG;
  assign wr_mask = reg_wr && reg_addr == `OFS_IRQ_MASK;
  assign rd_flags = reg_rd && reg_addr == `OFS_IRQ_FLAGS;

  // index 1 is the port clock error, index 0 the PLL lock
  assign evt_mask = {mask_r[`EVT_ASP_CLK_ERR_BIT], mask_r[`EVT_PLL_LOCK_BIT]};
  assign evt_set = {asp_clock_error, pll_locked && !pll_locked_d_r};
  assign flag_view = filter_on ? (flag_r & ~evt_mask) : flag_r;
  assign pending = |(flag_r & ~evt_mask);
  assign new_unmasked = |(evt_set & ~evt_mask);

  // config and mask registers; only documented fields of config are writable
  always_comb begin
    cfg_nxt = cfg_r;
    mask_nxt = mask_r;
    if (wr_cfg) begin
      cfg_nxt = `CFG_RESET;
      cfg_nxt[`CFG_POLARITY_BIT] = reg_wdata[`CFG_POLARITY_BIT];
      cfg_nxt[`CFG_STYLE_HI:`CFG_STYLE_LO] = reg_wdata[`CFG_STYLE_HI:`CFG_STYLE_LO];
      cfg_nxt[`CFG_FILTER_BIT] = reg_wdata[`CFG_FILTER_BIT];
    end
    if (wr_mask) begin
      mask_nxt = reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= `CFG_RESET;
      mask_r <= `MASK_RESET;
    end else begin
      cfg_r <= cfg_nxt;
      mask_r <= mask_nxt;
    end
  end

  // flags clear only where the read returned a one; a same-cycle event wins
  always_comb begin
    flag_nxt = flag_r;
    if (rd_flags) begin
      flag_nxt = flag_r & ~flag_view;
    end
    flag_nxt = flag_nxt | evt_set;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 2'h0;
      pll_locked_d_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      pll_locked_d_r <= pll_locked;
    end
  end

  // read data, one cycle after the strobe; unmapped offsets read zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_rd) begin
      rdata_nxt = 8'h00;
      case (reg_addr)
        `OFS_INPUT_MONITOR: rdata_nxt[`MON_TOP_BIT -: 4] = mon_levels;
        `OFS_IRQ_CONFIG: rdata_nxt = cfg_r;
        `OFS_IRQ_MASK: rdata_nxt = mask_r;
        `OFS_IRQ_FLAGS: begin
          rdata_nxt[`EVT_ASP_CLK_ERR_BIT] = flag_view[1];
          rdata_nxt[`EVT_PLL_LOCK_BIT] = flag_view[0];
        end
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= reg_rd;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rdata_valid = rvalid_r;

  pulse_timer #(
    .PULSE_CYCLES(PULSE_CYCLES),
    .PERIOD_CYCLES(PERIOD_CYCLES)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .periodic(style == STYLE_REPEAT && pending),
    .oneshot_en(style == STYLE_ONESHOT),
    .trigger(new_unmasked),
    .active(timer_active)
  );

  // the reserved style behaves as level so a stray write cannot silence the pin
  always_comb begin
    case (style)
      STYLE_LEVEL: irq_assert_c = pending;
      STYLE_RESERVED: irq_assert_c = pending;
      STYLE_REPEAT: irq_assert_c = timer_active;
      STYLE_ONESHOT: irq_assert_c = timer_active;
      default: irq_assert_c = pending;
    endcase
    irq_pin_nxt = polarity ? irq_assert_c : !irq_assert_c;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_pin_r <= 1'b1;
    end else begin
      irq_pin_r <= irq_pin_nxt;
    end
  end

  assign irq_pin = irq_pin_r;

  sequence s_mon_read;
    reg_rd && reg_addr == `OFS_INPUT_MONITOR;
  endsequence

  sequence s_flag_read;
    reg_rd && reg_addr == `OFS_IRQ_FLAGS;
  endsequence

  property p_mon_reserved;
    @(posedge clk) disable iff (!rst_n)
      s_mon_read |=> reg_rdata_valid && reg_rdata[3:0] == 4'h0;
  endproperty
  a_mon_reserved: assert property (p_mon_reserved) else $error("monitor low bits not zero");

  property p_mon_gated;
    @(posedge clk) disable iff (!rst_n)
      s_mon_read |=> reg_rdata[7] == ($past(pin_one_function_select) == 3'h1
                                      && $past(pin_sync[0]));
  endproperty
  a_mon_gated: assert property (p_mon_gated) else $error("input one level wrong");

  property p_polarity;
    @(posedge clk) disable iff (!rst_n)
      1'b1 |=> irq_pin == ($past(polarity) ? $past(irq_assert_c) : !$past(irq_assert_c));
  endproperty
  a_polarity: assert property (p_polarity) else $error("interrupt polarity wrong");

  property p_level;
    @(posedge clk) disable iff (!rst_n)
      (style == STYLE_LEVEL && pending && !polarity) |=> !irq_pin;
  endproperty
  a_level: assert property (p_level) else $error("level interrupt not asserted");

  property p_repeat_idle;
    @(posedge clk) disable iff (!rst_n)
      (style == STYLE_REPEAT && !pending) |-> !irq_assert_c;
  endproperty
  a_repeat_idle: assert property (p_repeat_idle) else $error("repeat asserts with no flag");

  property p_oneshot;
    @(posedge clk) disable iff (!rst_n)
      (style == STYLE_ONESHOT && new_unmasked && !wr_cfg) |=> irq_assert_c [*2];
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("one-shot pulse missing");

  property p_filter;
    @(posedge clk) disable iff (!rst_n)
      (s_flag_read ##0 (filter_on && mask_r[7])) |=> reg_rdata[7] == 1'b0;
  endproperty
  a_filter: assert property (p_filter) else $error("masked flag visible");

  property p_masked;
    @(posedge clk) disable iff (!rst_n)
      (mask_r[7] && mask_r[6]) |-> !pending;
  endproperty
  a_masked: assert property (p_masked) else $error("masked event pending");

  property p_set;
    @(posedge clk) disable iff (!rst_n)
      asp_clock_error |=> flag_r[1];
  endproperty
  a_set: assert property (p_set) else $error("clock error flag not set");

  property p_clear;
    @(posedge clk) disable iff (!rst_n)
      (s_flag_read ##0 (flag_view[0] && !evt_set[0])) |=> !flag_r[0] && reg_rdata[6];
  endproperty
  a_clear: assert property (p_clear) else $error("read did not clear lock flag");

  property p_flag_reserved;
    @(posedge clk) disable iff (!rst_n)
      s_flag_read |=> reg_rdata[5:0] == 6'h00;
  endproperty
  a_flag_reserved: assert property (p_flag_reserved) else $error("flag low bits not zero");
endmodule : irq_latch_mask_and_input_monitor

// [tb/host_model.sv]
/*
  Host model: drives the decoded register port with one-cycle strobes.
  Assumes the bench calls wr and rd, and that inputs change at falling edges.
*/
`timescale 1ns/100ps
module host_model (
  // clock
  input wire logic clk,
  // register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rdata_valid
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
    reg_addr = ~a;
  endtask : wr

  // a flag read also acknowledges it, which releases a level interrupt
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    v = reg_rdata_valid;
  endtask : rd
endmodule : host_model

// [tb/irq_latch_mask_and_input_monitor_bench.sv]
/*
  Self-checking bench of the interrupt latch, mask and input monitor block.
  Assumes short pulse counts are enough to show the timing styles.
*/
`timescale 1ns/100ps
`define CHK_EQ(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module irq_latch_mask_and_input_monitor_bench;
  import irq_pkg::*;
  localparam int PULSE = 8;
  localparam int PERIOD = 16;
  logic clk, rst_n, reg_wr, reg_rd, reg_rdata_valid, asp, pll, irq_pin;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] gin;
  logic [2:0] sel [4];
  int failures = 0;
  int checks_done = 0;

  always #10 clk = ~clk;

  host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid));

  irq_latch_mask_and_input_monitor #(.PULSE_CYCLES(PULSE), .PERIOD_CYCLES(PERIOD)) dut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid), .asp_clock_error(asp), .pll_locked(pll),
    .general_input_one(gin[3]), .general_input_two(gin[2]),
    .general_input_three(gin[1]), .general_input_four(gin[0]),
    .pin_one_function_select(sel[0]), .pin_two_function_select(sel[1]),
    .pin_three_function_select(sel[2]), .pin_four_function_select(sel[3]),
    .irq_pin(irq_pin));

  function automatic reg_byte_t exp_mon(input logic [3:0] g);
    reg_byte_t m;
    m = 8'h00;
    for (int j = 0; j < 4; j++) m[7-j] = g[3-j] & (sel[j] == 3'h1);
    return m;
  endfunction : exp_mon

  task automatic tally_and_finish();
    if (failures == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [7:0] d;
    logic v;
    host.rd(a, d, v);
    `CHK_EQ({nm, "_valid"}, 1'b1, v)
    `CHK_EQ(nm, e, d)
  endtask : rdchk

  task automatic fire(input logic src);
    @(negedge clk);
    if (src) pll = 1'b1;
    else asp = 1'b1;
    @(negedge clk);
    asp = 1'b0;
  endtask : fire

  // counts cycles with the pin at its active level
  task automatic count_irq(input int n, input logic pol, output int c);
    c = 0;
    repeat (n) begin
      @(negedge clk);
      if (irq_pin === pol) c++;
    end
  endtask : count_irq

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    tally_and_finish();
  end

  initial begin
    int c;
    reg_byte_t d;
    clk = 1'b0;
    rst_n = 1'b0;
    asp = 1'b0;
    pll = 1'b0;
    gin = 4'h0;
    for (int j = 0; j < 4; j++) sel[j] = 3'h1;
    void'($urandom(51));
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    `CHK_EQ("irq_reset", 1'b1, irq_pin)
    rdchk(8'h32, 8'h00, "cfg_reset");
    rdchk(8'h33, 8'hff, "mask_reset");
    rdchk(8'h36, 8'h00, "flag_reset");
    rdchk(8'h40, 8'h00, "unmapped");
    host.wr(8'h36, 8'hff);
    rdchk(8'h36, 8'h00, "flag_ro");
    for (int i = 0; i < 10; i++) begin
      gin = 4'($urandom);
      for (int j = 0; j < 4; j++) sel[j] = $urandom % 2 ? 3'h1 : 3'($urandom);
      repeat (3) @(negedge clk);
      host.wr(8'h2f, 8'($urandom));
      rdchk(8'h2f, exp_mon(gin), "monitor");
    end
    d = 8'($urandom);
    host.wr(8'h32, d);
    rdchk(8'h32, d & 8'he4, "cfg_rw");
    host.wr(8'h32, 8'h04);
    host.wr(8'h33, 8'hff);
    fire(1'b0);
    count_irq(6, 1'b0, c);
    `CHK_EQ("masked_irq", 0, c)
    rdchk(8'h36, 8'h00, "filter_hide");
    host.wr(8'h32, 8'h00);
    rdchk(8'h36, 8'h80, "filter_all");
    rdchk(8'h36, 8'h00, "self_clear");
    for (int k = 0; k < 4; k++) begin
      host.wr(8'h32, {k[0], 7'h00});
      host.wr(8'h33, k[1] ? 8'hbf : 8'h7f);
      fire(k[1]);
      repeat (2) @(negedge clk);
      count_irq(4, k[0], c);
      `CHK_EQ("level_hold", 4, c)
      rdchk(8'h36, k[1] ? 8'h40 : 8'h80, "level_flag");
      pll = 1'b0;
      repeat (3) @(negedge clk);
      `CHK_EQ("level_release", ~k[0], irq_pin)
    end
    host.wr(8'h33, 8'h3f);
    host.wr(8'h32, 8'h40);
    fire(1'b0);
    repeat (2) @(negedge clk);
    count_irq(3 * PERIOD, 1'b0, c);
    `CHK_EQ("repeat_cycles", 3 * PULSE, c)
    rdchk(8'h36, 8'h80, "repeat_flag");
    repeat (3) @(negedge clk);
    count_irq(PERIOD, 1'b0, c);
    `CHK_EQ("repeat_stop", 0, c)
    host.wr(8'h32, 8'he0);
    fire(1'b0);
    count_irq(3 * PERIOD, 1'b1, c);
    `CHK_EQ("oneshot_cycles", PULSE, c)
    rdchk(8'h36, 8'h80, "oneshot_flag");
    // corner case: a new event in the cycle of the clearing read keeps the flag
    fire(1'b0);
    fork
      rdchk(8'h36, 8'h80, "clear_race");
      fire(1'b0);
    join
    rdchk(8'h36, 8'h80, "set_wins");
    tally_and_finish();
  end
endmodule : irq_latch_mask_and_input_monitor_bench
